// ===== common/embedded_memory_pkg.sv
package embedded_memory_pkg;

    // ==========================================================
    // memory geometry
    localparam int RAM_WORDS = 128;              // words of the widest shape
    localparam int RAM_W     = 16;               // widest data path
    localparam int IDX_W     = 7;                // index into the word array
    localparam int ADDR_W    = 11;               // address of the narrowest shape
    localparam int LANE_W    = 4;                // lane select at the narrowest
    localparam int PAGE_W    = 2;                // upper address bits of a page

    // ==========================================================
    // content-addressable geometry
    localparam int CAM_N     = 32;
    localparam int CAM_W     = 32;
    localparam int CAM_IDX_W = 5;
    localparam int OUT_W     = 16;               // result lines per cycle
    localparam int LOCAL_N   = 10;               // local outputs, one doubled

    // ==========================================================
    // reset values
    localparam logic [RAM_W-1:0]  RAM_ZERO = 16'h0000;
    localparam logic [CAM_W-1:0]  CAM_ZERO = 32'h00000000;
    localparam logic [CAM_W-1:0]  CARE_ALL = 32'hFFFFFFFF;
    localparam logic [OUT_W-1:0]  OUT_ZERO = 16'h0000;

    // ==========================================================
    // modes and states
    typedef enum logic [1:0] {
        MODE_UNUSED = 2'b00,
        MODE_RAM    = 2'b01,
        MODE_ROM    = 2'b10,
        MODE_CAM    = 2'b11
    } blk_mode_t;

    typedef enum logic [2:0] {
        SHAPE_128X16  = 3'b000,
        SHAPE_256X8   = 3'b001,
        SHAPE_512X4   = 3'b010,
        SHAPE_1024X2  = 3'b011,
        SHAPE_2048X1  = 3'b100
    } shape_t;

    typedef enum logic [1:0] {
        CW_IDLE = 2'b00,
        CW_DATA = 2'b01,
        CW_MASK = 2'b10
    } cam_wr_state_t;

    // ==========================================================
    // carriers
    typedef struct packed {
        blk_mode_t          mode;
        shape_t             shape;
        logic               low_power;
        logic               deep_en;
        logic [PAGE_W-1:0]  page;
    } blk_cfg_t;

    typedef struct packed {
        logic [CAM_IDX_W-1:0] addr;
        logic [CAM_W-1:0]     data;
        logic [CAM_W-1:0]     dc;
        logic                 use_dc;
    } cam_wr_t;

endpackage

// ===== design/embedded_memory_block.sv
// Notes on behaviour
// - five aspect shapes, 128x16 down to 2048x1
// - write strobe made internally from clock
// - side by side blocks share one address
// - page decoder enables the shared line driver
// - low eleven bits to memory, upper to decoder
// - no double drive, no floating shared line
// - ten local outputs, nine of them distinct
// - cam holds 32 entries of 32 bits
// - parallel compare, match flag on any hit
// - don't care bits never block a match
// - encoded result gives matching entry address
// - unencoded result spans two cycles, 16 lines
// - cam write two cycles, three with mask
// - rom holds configured pattern as lookup
// - per block fast or low power, extra delay
// - unused block is powered down
`timescale 1ns/1ps
module embedded_memory_block (
    // clock and reset
    input  wire logic                                       clk,
    input  wire logic                                       rst_n,
    // configuration
    input  wire embedded_memory_pkg::blk_cfg_t              cfg,
    input  wire logic                                       cfg_load,
    input  wire logic [embedded_memory_pkg::IDX_W-1:0]      cfg_idx,
    input  wire logic [embedded_memory_pkg::RAM_W-1:0]      cfg_word,
    // memory access
    input  wire logic [embedded_memory_pkg::ADDR_W-1:0]     addr_lo,
    input  wire logic [embedded_memory_pkg::PAGE_W-1:0]     addr_hi,
    input  wire logic                                       wr_en,
    input  wire logic [embedded_memory_pkg::RAM_W-1:0]      wr_data,
    // memory outputs
    output logic [embedded_memory_pkg::RAM_W-1:0]           rd_data,
    output logic [embedded_memory_pkg::RAM_W-1:0]           tri_data,
    output logic                                            tri_oe,
    output logic [embedded_memory_pkg::LOCAL_N-1:0]         local_out,
    output logic                                            power_down,
    // cam write
    input  wire logic                                       cam_wr_req,
    input  wire embedded_memory_pkg::cam_wr_t               cam_wr,
    output logic                                            cam_busy,
    // cam search
    input  wire logic                                       cam_search,
    input  wire logic [embedded_memory_pkg::CAM_W-1:0]      cam_key,
    input  wire logic                                       cam_encoded,
    output logic                                            cam_match,
    output logic [embedded_memory_pkg::OUT_W-1:0]           cam_result,
    output logic                                            cam_upper
);

    // ==========================================================
    // elaboration checks
    if (embedded_memory_pkg::CAM_N != 2 * embedded_memory_pkg::OUT_W)
    begin : g_bad_split
        $error("cam entries must fill exactly two result cycles");
    end

    // ==========================================================
    // storage
    logic [embedded_memory_pkg::RAM_W-1:0] mem [embedded_memory_pkg::RAM_WORDS];
    logic [embedded_memory_pkg::CAM_W-1:0] cam_mem  [embedded_memory_pkg::CAM_N];
    logic [embedded_memory_pkg::CAM_W-1:0] care_mem [embedded_memory_pkg::CAM_N];

    // ==========================================================
    // address decode for the configured shape
    logic [2:0]                                 shp;
    logic [embedded_memory_pkg::IDX_W-1:0]      word_idx;
    logic [embedded_memory_pkg::LANE_W-1:0]     lane;
    logic [embedded_memory_pkg::RAM_W:0]        wdt;
    logic [embedded_memory_pkg::RAM_W-1:0]      lane_mask;
    logic [embedded_memory_pkg::RAM_W-1:0]      bit_we;
    logic [embedded_memory_pkg::RAM_W-1:0]      wr_repl;
    logic [embedded_memory_pkg::RAM_W-1:0]      rd_word;
    logic [embedded_memory_pkg::RAM_W-1:0]      rd_sel;
    logic [embedded_memory_pkg::RAM_W-1:0]      merged;
    logic                                       mem_mode;
    logic                                       ram_we;
    logic                                       page_hit;
    logic                                       drive_sel;

    // out-of-range shape codes fall back to the narrowest shape
    assign shp = (cfg.shape > embedded_memory_pkg::SHAPE_2048X1)
               ? 3'(embedded_memory_pkg::SHAPE_2048X1) : 3'(cfg.shape);
    // only the low eleven bits reach the array
    assign word_idx  = embedded_memory_pkg::IDX_W'(addr_lo >> shp);
    assign lane      = embedded_memory_pkg::LANE_W'(addr_lo
                     & embedded_memory_pkg::ADDR_W'((11'h001 << shp) - 11'h001));
    assign wdt       = 17'(17'h00010 >> shp);
    assign lane_mask = embedded_memory_pkg::RAM_W'((17'h00001 << wdt) - 17'h00001);
    assign rd_word   = mem[word_idx];
    assign rd_sel    = embedded_memory_pkg::RAM_W'(rd_word
                     >> (5'(lane) << (3'h4 - shp))) & lane_mask;

    // per bit: which lane owns it, and the replicated write data
    for (genvar b = 0; b < embedded_memory_pkg::RAM_W; b++)
    begin : g_bit
        assign bit_we[b]  = (4'(b >> (3'h4 - shp)) == lane);
        assign wr_repl[b] = wr_data[4'(b) & 4'(wdt - 17'h00001)];
    end

    assign merged   = (rd_word & ~bit_we) | (wr_repl & bit_we);
    assign mem_mode = (cfg.mode == embedded_memory_pkg::MODE_RAM)
                   || (cfg.mode == embedded_memory_pkg::MODE_ROM);
    // the strobe is internal: the clock edge itself writes
    assign ram_we   = wr_en && (cfg.mode == embedded_memory_pkg::MODE_RAM);
    // upper address bits feed only the page decoder
    assign page_hit  = (addr_hi == cfg.page);
    // a lone RAM or ROM block always drives; deep members drive only their page
    assign drive_sel = mem_mode && (!cfg.deep_en || page_hit);

    // array write: configuration preload wins over a user write
    always_ff @(posedge clk)
    begin
        if (cfg_load)
            mem[cfg_idx] <= cfg_word;
        else if (ram_we)
            mem[word_idx] <= merged;
    end

    // ==========================================================
    // read pipeline; low power inserts one stage of delay
    logic [embedded_memory_pkg::RAM_W-1:0]   stg_data_ff;
    logic                                    stg_oe_ff;
    logic [embedded_memory_pkg::RAM_W-1:0]   rd_data_ff;
    logic                                    tri_oe_ff;
    logic                                    power_down_ff;
    logic [embedded_memory_pkg::RAM_W-1:0]   nxt_rd;
    logic                                    nxt_oe;

    assign nxt_rd = cfg.low_power ? stg_data_ff : rd_sel;
    assign nxt_oe = cfg.low_power ? stg_oe_ff : drive_sel;

    // outputs frozen at zero while unused, so nothing toggles
    always_ff @(posedge clk)
    begin
        if (!rst_n || !mem_mode)
        begin
            stg_data_ff <= embedded_memory_pkg::RAM_ZERO;
            stg_oe_ff   <= 1'b0;
            rd_data_ff  <= embedded_memory_pkg::RAM_ZERO;
            tri_oe_ff   <= 1'b0;
        end
        else
        begin
            stg_data_ff <= rd_sel;
            stg_oe_ff   <= drive_sel;
            rd_data_ff  <= nxt_rd;
            tri_oe_ff   <= nxt_oe;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            power_down_ff <= 1'b0;
        else
            power_down_ff <= (cfg.mode == embedded_memory_pkg::MODE_UNUSED);
    end

    // the same word goes to all three destinations; blocks side by side
    // see one address and need no extra control
    assign rd_data    = rd_data_ff;
    assign tri_data   = rd_data_ff;
    assign tri_oe     = tri_oe_ff;
    assign power_down = power_down_ff;
    // nine distinct local lines, the top one doubled
    assign local_out  = {rd_data_ff[8], rd_data_ff[8:0]};

    // ==========================================================
    // cam write sequencer
    embedded_memory_pkg::cam_wr_state_t   cw_state_ff;
    embedded_memory_pkg::cam_wr_state_t   nxt_cw_state;
    embedded_memory_pkg::cam_wr_t         cw_hold_ff;
    logic [embedded_memory_pkg::CAM_N-1:0] valid_ff;
    logic                                 cam_mode;
    logic                                 cw_take;
    logic                                 cam_busy_ff;

    assign cam_mode = (cfg.mode == embedded_memory_pkg::MODE_CAM);
    assign cw_take  = cam_wr_req && (cw_state_ff == embedded_memory_pkg::CW_IDLE);
    assign cam_busy = cam_busy_ff;

    // a mask write needs one extra cycle
    always_comb
    begin
        case (cw_state_ff)
            embedded_memory_pkg::CW_IDLE:
                nxt_cw_state = cw_take ? embedded_memory_pkg::CW_DATA
                                       : embedded_memory_pkg::CW_IDLE;
            embedded_memory_pkg::CW_DATA:
                nxt_cw_state = cw_hold_ff.use_dc ? embedded_memory_pkg::CW_MASK
                                                 : embedded_memory_pkg::CW_IDLE;
            default:
                nxt_cw_state = embedded_memory_pkg::CW_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            cw_state_ff <= embedded_memory_pkg::CW_IDLE;
            cam_busy_ff <= 1'b0;
        end
        else
        begin
            cw_state_ff <= nxt_cw_state;
            // busy follows the next state, so the port stays a plain flop
            cam_busy_ff <= (nxt_cw_state != embedded_memory_pkg::CW_IDLE);
        end
    end

    always_ff @(posedge clk)
    begin
        if (cw_take)
            cw_hold_ff <= cam_wr;
    end

    // data cycle stores the word; without a mask every bit counts
    always_ff @(posedge clk)
    begin
        if (cw_state_ff == embedded_memory_pkg::CW_DATA)
        begin
            cam_mem[cw_hold_ff.addr]  <= cw_hold_ff.data;
            care_mem[cw_hold_ff.addr] <= embedded_memory_pkg::CARE_ALL;
        end
        else if (cw_state_ff == embedded_memory_pkg::CW_MASK)
            care_mem[cw_hold_ff.addr] <= ~cw_hold_ff.dc;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            valid_ff <= embedded_memory_pkg::CAM_ZERO;
        else if (cw_state_ff == embedded_memory_pkg::CW_DATA)
            valid_ff[cw_hold_ff.addr] <= 1'b1;
    end

    // ==========================================================
    // parallel compare
    logic [embedded_memory_pkg::CAM_N-1:0]  hits;
    logic [embedded_memory_pkg::CAM_IDX_W-1:0] enc;
    logic                                   search_go;

    for (genvar e = 0; e < embedded_memory_pkg::CAM_N; e++)
    begin : g_cmp
        assign hits[e] = valid_ff[e] && (((cam_mem[e] ^ cam_key)
                       & care_mem[e]) == embedded_memory_pkg::CAM_ZERO);
    end

    // lowest entry wins; duplicates are the user's hazard
    function automatic logic [embedded_memory_pkg::CAM_IDX_W-1:0]
        first_hit(input logic [embedded_memory_pkg::CAM_N-1:0] v);
        logic [embedded_memory_pkg::CAM_IDX_W-1:0] r;
        r = '0;
        for (int i = embedded_memory_pkg::CAM_N - 1; i >= 0; i--)
            if (v[i])
                r = embedded_memory_pkg::CAM_IDX_W'(i);
        return r;
    endfunction

    assign enc       = first_hit(hits);
    assign search_go = cam_search && cam_mode;

    // ==========================================================
    // registered result
    logic                                  cam_match_ff;
    logic [embedded_memory_pkg::OUT_W-1:0] cam_result_ff;
    logic [embedded_memory_pkg::OUT_W-1:0] upper_hold_ff;
    logic                                  cam_upper_ff;
    logic                                  pend_ff;

    always_ff @(posedge clk)
    begin
        if (!rst_n || !cam_mode)
        begin
            cam_match_ff  <= 1'b0;
            cam_result_ff <= embedded_memory_pkg::OUT_ZERO;
            upper_hold_ff <= embedded_memory_pkg::OUT_ZERO;
            cam_upper_ff  <= 1'b0;
            pend_ff       <= 1'b0;
        end
        else if (search_go)
        begin
            cam_match_ff  <= |hits;
            cam_result_ff <= cam_encoded
                ? embedded_memory_pkg::OUT_W'(enc)
                : hits[embedded_memory_pkg::OUT_W-1:0];
            upper_hold_ff <= hits[embedded_memory_pkg::CAM_N-1:
                                  embedded_memory_pkg::OUT_W];
            cam_upper_ff  <= 1'b0;
            pend_ff       <= !cam_encoded;
        end
        else if (pend_ff)
        begin
            cam_result_ff <= upper_hold_ff;
            cam_upper_ff  <= 1'b1;
            pend_ff       <= 1'b0;
        end
    end

    assign cam_match  = cam_match_ff;
    assign cam_result = cam_result_ff;
    assign cam_upper  = cam_upper_ff;

    // ==========================================================
    // checks
    ram_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        !$past(ram_we) && !$past(cfg_load) && $stable(word_idx)
        |-> $stable(rd_word))
        else $error("array word changed without a write");

    page_oe_a: assert property (@(posedge clk) disable iff (!rst_n)
        !cfg.low_power && $past(!cfg.low_power) && $past(mem_mode)
        |-> tri_oe == $past(mem_mode && (!cfg.deep_en || page_hit)))
        else $error("shared driver not following page decode");

    no_float_a: assert property (@(posedge clk) disable iff (!rst_n)
        mem_mode && !cfg.deep_en && $past(mem_mode && !cfg.deep_en, 2)
        && $past(mem_mode && !cfg.deep_en) |-> tri_oe)
        else $error("lone block left its line undriven");

    local_dup_a: assert property (@(posedge clk) disable iff (!rst_n)
        local_out[9] == local_out[8] && local_out[8:0] == rd_data[8:0])
        else $error("local outputs wrong");

    match_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
        search_go ##1 cam_mode |-> cam_match == $past(|hits))
        else $error("match flag disagrees with compare");

    enc_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
        search_go && cam_encoded && (|hits) ##1 cam_mode
        |-> $past(hits) == ($past(hits) | (32'h1 << cam_result[4:0])))
        else $error("encoded result names a non-matching entry");

    unenc_split_a: assert property (@(posedge clk) disable iff (!rst_n)
        search_go && !cam_encoded ##1 cam_mode && !search_go ##1 cam_mode
        |-> cam_upper && cam_result == $past(hits[31:16], 2)
            && $past(cam_result) == $past(hits[15:0], 2))
        else $error("unencoded halves out of order");

    cam_wr_len_a: assert property (@(posedge clk) disable iff (!rst_n)
        cw_take && !cam_wr.use_dc |=> cam_busy ##1 !cam_busy)
        else $error("plain cam write not two cycles");

    cam_mask_len_a: assert property (@(posedge clk) disable iff (!rst_n)
        cw_take && cam_wr.use_dc |=> cam_busy [*2] ##1 !cam_busy)
        else $error("masked cam write not three cycles");

    slow_delay_a: assert property (@(posedge clk) disable iff (!rst_n)
        cfg.low_power && mem_mode && $past(cfg.low_power && mem_mode)
        && $past(cfg.low_power && mem_mode, 2)
        |-> rd_data == $past(rd_sel, 2))
        else $error("low power read latency wrong");

    unused_off_a: assert property (@(posedge clk) disable iff (!rst_n)
        $past(rst_n) && $past(cfg.mode == embedded_memory_pkg::MODE_UNUSED)
        |-> power_down && rd_data == 16'h0000 && !tri_oe)
        else $error("unused block not powered down");

    hold_res_a: assert property (@(posedge clk) disable iff (!rst_n)
        cam_mode && $past(cam_mode) && !$past(search_go) && !$past(pend_ff)
        |-> $stable(cam_match) && $stable(cam_result))
        else $error("cam result moved without a search");

endmodule

// ===== tb/cam_user_model.sv
`timescale 1ns/1ps
// ==========================================================
// neighbouring logic cell that feeds the cam write and search ports
module cam_user_model (
    // clock
    input  wire logic                                  clk,
    // from the block
    input  wire logic                                  cam_busy,
    // to the block
    output logic                                       cam_wr_req,
    output embedded_memory_pkg::cam_wr_t               cam_wr,
    output logic                                       cam_search,
    output logic [embedded_memory_pkg::CAM_W-1:0]      cam_key,
    output logic                                       cam_encoded
);
    // quiet lines at time zero
    initial
    begin
        cam_wr_req  = 1'b0;
        cam_wr      = '0;
        cam_search  = 1'b0;
        cam_key     = 32'h00000000;
        cam_encoded = 1'b0;
    end

    // one word per request; the next waits until busy drops
    task automatic put_word(input logic [4:0] a, input logic [31:0] d,
                            input logic [31:0] m, input logic u,
                            output logic [3:0] n);
        @(negedge clk);
        cam_wr_req = 1'b1;
        cam_wr     = '{addr: a, data: d, dc: m, use_dc: u};
        @(negedge clk);
        cam_wr_req = 1'b0;
        cam_wr     = ~cam_wr; // stale fields must not be reused
        n = 4'h0;
        while (cam_busy === 1'b1 && n < 4'h8)
        begin
            n++;
            @(negedge clk);
        end
    endtask

    // callers ask for encoded results only on keys known unique
    task automatic look(input logic [31:0] k, input logic e);
        @(negedge clk);
        cam_search  = 1'b1;
        cam_key     = k;
        cam_encoded = e;
        @(negedge clk);
        cam_search  = 1'b0;
        cam_key     = ~k; // released key shows no old value
    endtask
endmodule

// ===== tb/embedded_memory_block_tb.sv
`timescale 1ns/1ps
module embedded_memory_block_tb;
    // ==========================================================
    // signals and reference model
    logic                          clk, rst_n, cfg_load, wr_en, tri_oe;
    logic                          power_down, cam_wr_req, cam_busy;
    logic                          cam_search, cam_encoded, cam_match;
    logic                          cam_upper;
    embedded_memory_pkg::blk_cfg_t cfg;
    embedded_memory_pkg::cam_wr_t  cam_wr;
    logic [6:0]                    cfg_idx;
    logic [15:0]                   cfg_word, wr_data, rd_data, tri_data;
    logic [15:0]                   cam_result;
    logic [10:0]                   addr_lo, a;
    logic [1:0]                    addr_hi;
    logic [9:0]                    local_out;
    logic [31:0]                   cam_key, ref_v;
    logic [31:0]                   seed = 32'h00000052;
    logic [2047:0]                 ref_mem;
    logic [31:0]                   ref_d [32];
    logic [31:0]                   ref_m [32];
    int                            err_count, samples_checked;
    int                            cyc = 0;

    embedded_memory_block DUT (.clk, .rst_n, .cfg, .cfg_load, .cfg_idx,
        .cfg_word, .addr_lo, .addr_hi, .wr_en, .wr_data, .rd_data,
        .tri_data, .tri_oe, .local_out, .power_down, .cam_wr_req, .cam_wr,
        .cam_busy, .cam_search, .cam_key, .cam_encoded, .cam_match,
        .cam_result, .cam_upper);

    cam_user_model u_user (.clk, .cam_busy, .cam_wr_req, .cam_wr,
        .cam_search, .cam_key, .cam_encoded);

    // ==========================================================
    // helpers
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk(input string nm, input logic [31:0] e, g);
        samples_checked++;
        if (g !== e)
        begin
            $display("unexpected %s: expected %h seen %h", nm, e, g);
            err_count++;
        end
    endtask

    task automatic give_verdict();
        if (err_count == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // lane bits sit at a*width whatever the shape
    task automatic mem_wr(input logic [10:0] ad, input logic [15:0] d);
        int w;
        w = (cfg.shape > 4) ? 1 : 16 >> cfg.shape;
        @(negedge clk);
        addr_lo = ad;
        wr_data = d;
        wr_en   = 1'b1;
        @(negedge clk);
        wr_en   = 1'b0;
        if (cfg.mode == embedded_memory_pkg::MODE_RAM)
            for (int i = 0; i < w; i++) ref_mem[ad*w+i] = d[i];
    endtask

    task automatic mem_rd(input logic [10:0] ad);
        int w;
        logic [15:0] e;
        logic oe;
        w  = (cfg.shape > 4) ? 1 : 16 >> cfg.shape;
        e  = 16'h0000;
        for (int i = 0; i < w; i++) e[i] = ref_mem[ad*w+i];
        oe = !cfg.deep_en || addr_hi == cfg.page;
        @(negedge clk);
        addr_lo = ad;
        repeat (cfg.low_power ? 2 : 1) @(negedge clk);
        chk("rd_data", e, rd_data);
        chk("tri_data", e, tri_data);
        chk("tri_oe", oe, tri_oe);
        chk("local_out", {e[8], e[8:0]}, local_out);
    endtask

    function automatic logic [31:0] hits(input logic [31:0] k);
        for (int i = 0; i < 32; i++)
            hits[i] = ref_v[i] && (((k ^ ref_d[i]) & ~ref_m[i]) == 0);
    endfunction

    task automatic cam_put(input logic [4:0] ad, input logic [31:0] d,
                           input logic [31:0] m, input logic u);
        logic [3:0] n;
        u_user.put_word(ad, d, m, u, n);
        chk("cam_busy cycles", u ? 2 : 1, n);
        ref_d[ad] = d;
        ref_m[ad] = u ? m : 32'h00000000;
        ref_v[ad] = 1'b1;
    endtask

    task automatic cam_find(input logic [31:0] k, input logic e);
        logic [31:0] h;
        int lo;
        h  = hits(k);
        lo = 0;
        for (int i = 31; i >= 0; i--) if (h[i]) lo = i;
        u_user.look(k, e);
        chk("cam_match", |h, cam_match);
        chk("cam_upper", 0, cam_upper);
        if (e && |h)
            chk("cam_result", lo, cam_result);
        if (!e)
        begin
            chk("cam_result lo", h[15:0], cam_result);
            @(negedge clk);
            chk("cam_result hi", h[31:16], cam_result);
            chk("cam_upper", 1, cam_upper);
            chk("cam_match held", |h, cam_match);
        end
    endtask

    // ==========================================================
    // clock and hang guard, sized well above the expected run
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_count++;
            give_verdict();
        end
    end

    // ==========================================================
    // main sequence
    initial
    begin
        rst_n = 1'b0;
        cfg = '0;
        {wr_en, cfg_idx, cfg_word, wr_data} = '0;
        // zero every array word first, so no unknown reaches a port
        cfg_load = 1'b1;
        {addr_lo, addr_hi} = '0;
        ref_mem = '0;
        ref_v = 32'h00000000;
        repeat (10) @(negedge clk);
        chk("power_down", 0, power_down);
        rst_n = 1'b1;
        @(negedge clk);
        chk("power_down", 1, power_down);
        for (int w = 1; w < 128; w++)
        begin
            cfg_idx = 7'(w);
            @(negedge clk);
        end
        cfg_load = 1'b0;
        cfg.mode = embedded_memory_pkg::MODE_RAM;
        @(negedge clk);
        chk("power_down", 0, power_down);
        for (int s = 0; s < 5; s++)
        begin
            cfg.shape = embedded_memory_pkg::shape_t'(s);
            repeat (4)
            begin
                a = 11'(xs() & ((128 << s) - 1));
                mem_wr(a, 16'(xs()));
                mem_rd(a);
            end
        end
        // spare shape codes behave as the narrowest shape
        cfg.shape = embedded_memory_pkg::shape_t'(7);
        mem_wr(a, 16'(xs()));
        mem_rd(a);
        cfg.shape = embedded_memory_pkg::SHAPE_128X16;
        @(negedge clk);
        cfg_load = 1'b1;
        cfg_idx  = 7'h33;
        cfg_word = 16'hA5C3;
        @(negedge clk);
        cfg_load = 1'b0;
        ref_mem[51*16 +: 16] = 16'hA5C3;
        cfg.mode = embedded_memory_pkg::MODE_ROM;
        mem_wr(11'h033, 16'h1234);
        mem_rd(11'h033);
        cfg.mode = embedded_memory_pkg::MODE_RAM;
        cfg.deep_en = 1'b1;
        cfg.page = 2'h2;
        for (int h = 0; h < 4; h++)
        begin
            addr_hi = h[1:0];
            mem_rd(11'h033);
        end
        cfg.deep_en = 1'b0;
        cfg.low_power = 1'b1;
        mem_wr(11'h010, 16'h5AF0);
        mem_rd(11'h010);
        cfg.low_power = 1'b0;
        cfg.mode = embedded_memory_pkg::MODE_CAM;
        cam_find(xs(), 1'b0);
        for (int i = 0; i < 32; i++)
            cam_put(i[4:0], xs(), 32'h00000000, 1'b0);
        cam_put(5'h14, ref_d[7], 32'h00000000, 1'b0);
        cam_put(5'h05, ref_d[5], 32'h00FF00F0, 1'b1);
        cam_find(ref_d[7], 1'b0);
        cam_find(ref_d[5] ^ 32'h00A50030, 1'b0);
        cam_find(ref_d[5] ^ 32'h01000000, 1'b1);
        cam_find(xs(), 1'b0);
        for (int i = 0; i < 8; i++)
            cam_find(ref_d[24+i], i[0]);
        give_verdict();
    end
endmodule
